// ---- sfr_guard_defines.svh ----
`ifndef SFR_GUARD_DEFINES_SVH
`define SFR_GUARD_DEFINES_SVH

// special function register page and its classes (low address byte)
`define SFR_PAGE        8'hFF
`define CORE_SFR_LO     8'h00
`define CORE_SFR_HI     8'h3F
`define MMU_SFR_LO      8'h40
`define MMU_SFR_HI      8'h5F
`define UNIT_SFR_TAG    2'h2
`define NUM_UNITS       4
`define UNIT_CIPHER     0

// memory management configuration registers (low address byte)
`define MMU_STB_LO      8'h40
`define MMU_STB_HI      8'h41
`define MMU_USR_GRANT   8'h42
`define MMU_ISO_GRANT   8'h43
`define MMU_BOOT_DONE   8'h44
`define MMU_SEG_FIRST   8'h48
`define SEG_STRIDE      4
`define SEG_OFS_BASE    2'h0
`define SEG_OFS_LIMIT   2'h1
`define SEG_OFS_EN      2'h2
`define NUM_SEGS        4

// fixed firewall partition: isolated mode lives at and above the split
`define FW_SPLIT        16'h8000

// reset values
`define RST_STB         16'h0000
`define RST_GRANT       4'h0
`define RST_SEG_BASE    8'hFF
`define RST_SEG_LIMIT   8'h00
`define RST_SEG_EN      1'b0
`define RST_BYTE        8'h00

`endif

// ---- sfr_guard_pkg.sv ----
package sfr_guard_pkg;
   // cpu privilege modes; code 3 is illegal and always denied
   typedef enum logic [1:0] {
      MODE_SYSTEM,
      MODE_USER,
      MODE_ISOLATED
   } cpu_mode_e;

   // reason reported with an access violation
   typedef enum logic [2:0] {
      FLT_NONE,
      FLT_MMU_CFG,
      FLT_UNIT,
      FLT_SEGMENT,
      FLT_PARTITION,
      FLT_MODE
   } fault_e;
endpackage

// ---- sfr_class_gate.sv ----
`timescale 1ns/1ps
`include "sfr_guard_defines.svh"

module sfr_class_gate (
   // access under test
   input  wire logic [7:0]                addr_lo,
   input  wire sfr_guard_pkg::cpu_mode_e  mode,
   // configured unit grants and strap
   input  wire logic [`NUM_UNITS-1:0]     usr_grant,
   input  wire logic [`NUM_UNITS-1:0]     iso_grant,
   input  wire logic                      cipher_en,
   // classification and verdict
   output logic                           is_core,
   output logic                           is_mmu,
   output logic                           is_unit,
   output logic                           unit_ok
);
   import sfr_guard_pkg::*;

   logic [`NUM_UNITS-1:0] unit_hit;
   logic [`NUM_UNITS-1:0] unit_open;

   // address classes of the register page
   assign is_core = (addr_lo <= `CORE_SFR_HI);
   assign is_mmu  = (addr_lo >= `MMU_SFR_LO) && (addr_lo <= `MMU_SFR_HI);
   assign is_unit = (addr_lo[7:6] == `UNIT_SFR_TAG);

   // per unit, only if present (cipher unit needs cipher_en): system always, other modes only by grant
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_UNITS; gi++) begin : g_unit
         logic present;
         assign present = (gi != `UNIT_CIPHER) || cipher_en;
         assign unit_hit[gi] = (addr_lo[5:4] == 2'(gi));
         always_comb begin
            unit_open[gi] = 1'b0;
            if (present) begin
               unique case (mode)
                  MODE_SYSTEM:   unit_open[gi] = 1'b1;
                  MODE_USER:     unit_open[gi] = usr_grant[gi];
                  MODE_ISOLATED: unit_open[gi] = iso_grant[gi];
                  default:       unit_open[gi] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   assign unit_ok = |(unit_hit & unit_open);
endmodule // sfr_class_gate

// ---- seg_partition_gate.sv ----
`timescale 1ns/1ps
`include "sfr_guard_defines.svh"

module seg_partition_gate (
   // access under test
   input  wire logic [15:0]                addr,
   input  wire sfr_guard_pkg::cpu_mode_e   mode,
   // segment table contents
   input  wire logic [`NUM_SEGS*8-1:0]     seg_base,
   input  wire logic [`NUM_SEGS*8-1:0]     seg_limit,
   input  wire logic [`NUM_SEGS-1:0]       seg_en,
   // verdicts
   output logic                            part_ok,
   output logic                            seg_ok
);
   import sfr_guard_pkg::*;

   logic [`NUM_SEGS-1:0] seg_hit;
   logic                 upper;

   // fixed split, no input can move it
   assign upper   = (addr >= `FW_SPLIT);
   assign part_ok = (mode == MODE_ISOLATED) ? upper : !upper;

   // page-granular window compare per segment
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_SEGS; gi++) begin : g_seg
         assign seg_hit[gi] = seg_en[gi]
            && (addr[15:8] >= seg_base[gi*8 +: 8])
            && (addr[15:8] <= seg_limit[gi*8 +: 8]);
      end
   endgenerate

   // system mode is not bound by segments
   assign seg_ok = (mode == MODE_SYSTEM) || (|seg_hit);
endmodule // seg_partition_gate

// ---- mode_sfr_mmu_guard.sv ----
// What this block does
// - memory management registers read and written only in privileged mode
// - segment table base pointer changes only in privileged mode
// - privileged code may reach all hardware unit registers present in the configuration (cipher unit only with the strap set)
// - unprivileged default: only cpu core registers reachable, units blocked
// - unit registers open to unprivileged code only by explicit grant
// - security attributes take defaults at reset, boot firmware completes them
// - every memory segment disabled after reset
// - firewall partition fixed, nothing can move it
// - only unit grants for user and isolated modes are configurable
// - register contents and access settings have reset defaults
// - block cipher unit unavailable in reduced configurations
`timescale 1ns/1ps
`include "sfr_guard_defines.svh"

module mode_sfr_mmu_guard (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   // configuration strap pin
   input  wire logic                      cipher_strap,
   // cpu access side
   input  wire logic                      cpu_req,
   input  wire logic                      cpu_we,
   input  wire logic [15:0]               cpu_addr,
   input  wire logic [7:0]                cpu_wdata,
   input  wire sfr_guard_pkg::cpu_mode_e  cpu_mode,
   // answer to the cpu
   output logic                           cpu_rvalid,
   output logic [7:0]                     cpu_rdata,
   output logic                           cpu_fault,
   output sfr_guard_pkg::fault_e          cpu_fault_cause,
   // forwarded access to registers and memory
   output logic                           res_req,
   output logic                           res_we,
   output logic [15:0]                    res_addr,
   output logic [7:0]                     res_wdata,
   // attributes seen by the memory management unit
   output logic [15:0]                    seg_table_base,
   output logic                           attrs_ready
);
   import sfr_guard_pkg::*;

   // strap synchroniser
   logic                      strap_meta_ff;
   logic                      strap_sync_ff;
   // configuration state
   logic [15:0]               stb_ff;
   logic [`NUM_UNITS-1:0]     usr_grant_ff;
   logic [`NUM_UNITS-1:0]     iso_grant_ff;
   logic                      boot_done_ff;
   logic [`NUM_SEGS*8-1:0]    seg_base_ff;
   logic [`NUM_SEGS*8-1:0]    seg_limit_ff;
   logic [`NUM_SEGS-1:0]      seg_en_ff;
   // answer state
   logic                      rvalid_ff;
   logic [7:0]                rdata_ff;
   logic                      fault_ff;
   fault_e                    cause_ff;
   logic                      res_req_ff;
   logic                      res_we_ff;
   logic [15:0]               res_addr_ff;
   logic [7:0]                res_wdata_ff;
   // decode and verdict
   logic                      in_page;
   logic                      is_core;
   logic                      is_mmu;
   logic                      is_unit;
   logic                      unit_ok;
   logic                      part_ok;
   logic                      seg_ok;
   logic                      mode_legal;
   logic                      mmu_ok;
   logic                      allow;
   logic                      cfg_wr;
   logic                      cfg_rd;
   fault_e                    nxt_cause;
   logic [7:0]                nxt_rdata;
   logic [7:0]                seg_rel;
   logic [1:0]                seg_idx;

   // cipher presence strap through two flip-flops
   // pin may move at any time, unit follows the second stage, two edges behind the pin
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         strap_meta_ff <= 1'b0;
         strap_sync_ff <= 1'b0;
      end else begin
         strap_meta_ff <= cipher_strap;
         strap_sync_ff <= strap_meta_ff;
      end
   end

   // register page classification and unit grants
   sfr_class_gate u_class (
      .addr_lo   (cpu_addr[7:0]),
      .mode      (cpu_mode),
      .usr_grant (usr_grant_ff),
      .iso_grant (iso_grant_ff),
      .cipher_en (strap_sync_ff),
      .is_core   (is_core),
      .is_mmu    (is_mmu),
      .is_unit   (is_unit),
      .unit_ok   (unit_ok)
   );

   // memory partition and segment checks
   seg_partition_gate u_mem (
      .addr      (cpu_addr),
      .mode      (cpu_mode),
      .seg_base  (seg_base_ff),
      .seg_limit (seg_limit_ff),
      .seg_en    (seg_en_ff),
      .part_ok   (part_ok),
      .seg_ok    (seg_ok)
   );

   // mode legality and register page hit
   // code 3 of the mode field is never a legal mode
   assign in_page    = (cpu_addr[15:8] == `SFR_PAGE);
   assign mode_legal = (cpu_mode == MODE_SYSTEM)
                    || (cpu_mode == MODE_USER)
                    || (cpu_mode == MODE_ISOLATED);
   assign mmu_ok     = (cpu_mode == MODE_SYSTEM);

   // access verdict with cause, first failing check wins
   // an illegal mode is refused before any address is looked at
   always_comb begin
      nxt_cause = FLT_NONE;
      if (!mode_legal) begin
         nxt_cause = FLT_MODE;
      end else if (in_page) begin
         if (is_mmu && !mmu_ok) begin
            nxt_cause = FLT_MMU_CFG;
         end else if (is_unit && !unit_ok) begin
            nxt_cause = FLT_UNIT;
         end else if (!is_core && !is_mmu && !is_unit) begin
            // unmapped holes of the page refused like a closed unit
            nxt_cause = FLT_UNIT;
         end
      end else if (!part_ok) begin
         nxt_cause = FLT_PARTITION;
      end else if (cpu_mode != MODE_SYSTEM && !boot_done_ff) begin
         nxt_cause = FLT_SEGMENT;
      end else if (!seg_ok) begin
         nxt_cause = FLT_SEGMENT;
      end
   end

   // configuration range is served here and never forwarded
   assign allow  = (nxt_cause == FLT_NONE);
   assign cfg_wr = cpu_req && cpu_we && allow && in_page && is_mmu;
   assign cfg_rd = cpu_req && !cpu_we && allow && in_page && is_mmu;

   // segment slot addressed inside the configuration range
   // wraps below the first slot, the range test guards it
   assign seg_rel = cpu_addr[7:0] - `MMU_SEG_FIRST;
   assign seg_idx = seg_rel[3:2];

   // segment table base pointer, privileged writes only
   // byte halves written separately, no partial-update lock
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stb_ff <= `RST_STB;
      end else if (cfg_wr && cpu_addr[7:0] == `MMU_STB_LO) begin
         stb_ff[7:0] <= cpu_wdata;
      end else if (cfg_wr && cpu_addr[7:0] == `MMU_STB_HI) begin
         stb_ff[15:8] <= cpu_wdata;
      end
   end

   // unit grants, the only configurable access attributes
   // reset leaves every unit shut to user and isolated code
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         usr_grant_ff <= `RST_GRANT;
         iso_grant_ff <= `RST_GRANT;
      end else if (cfg_wr && cpu_addr[7:0] == `MMU_USR_GRANT) begin
         usr_grant_ff <= cpu_wdata[`NUM_UNITS-1:0];
      end else if (cfg_wr && cpu_addr[7:0] == `MMU_ISO_GRANT) begin
         iso_grant_ff <= cpu_wdata[`NUM_UNITS-1:0];
      end
   end

   // boot firmware marks attribute setup complete, sticky until reset
   // set only, no write can drop it again before reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         boot_done_ff <= 1'b0;
      end else if (cfg_wr && cpu_addr[7:0] == `MMU_BOOT_DONE
                   && cpu_wdata[0]) begin
         boot_done_ff <= 1'b1;
      end
   end

   // segment table entries, disabled at reset
   // base above limit matches no page even once enabled
   genvar gs;
   generate
      for (gs = 0; gs < `NUM_SEGS; gs++) begin : g_segreg
         logic hit;
         assign hit = cfg_wr && (cpu_addr[7:0] >= `MMU_SEG_FIRST)
                   && (seg_idx == 2'(gs)) && (seg_rel[7:4] == 4'h0);
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               seg_base_ff[gs*8 +: 8]  <= `RST_SEG_BASE;
               seg_limit_ff[gs*8 +: 8] <= `RST_SEG_LIMIT;
               seg_en_ff[gs]           <= `RST_SEG_EN;
            end else if (hit) begin
               unique case (seg_rel[1:0])
                  `SEG_OFS_BASE:  seg_base_ff[gs*8 +: 8]  <= cpu_wdata;
                  `SEG_OFS_LIMIT: seg_limit_ff[gs*8 +: 8] <= cpu_wdata;
                  `SEG_OFS_EN:    seg_en_ff[gs]           <= cpu_wdata[0];
                  default:        seg_en_ff[gs]           <= seg_en_ff[gs];
               endcase
            end
         end
      end
   endgenerate

   // read mux over the configuration registers
   // unused slots read back zero
   always_comb begin
      nxt_rdata = `RST_BYTE;
      if (cpu_addr[7:0] == `MMU_STB_LO) begin
         nxt_rdata = stb_ff[7:0];
      end else if (cpu_addr[7:0] == `MMU_STB_HI) begin
         nxt_rdata = stb_ff[15:8];
      end else if (cpu_addr[7:0] == `MMU_USR_GRANT) begin
         nxt_rdata = {4'h0, usr_grant_ff};
      end else if (cpu_addr[7:0] == `MMU_ISO_GRANT) begin
         nxt_rdata = {4'h0, iso_grant_ff};
      end else if (cpu_addr[7:0] == `MMU_BOOT_DONE) begin
         nxt_rdata = {7'h00, boot_done_ff};
      end else if (cpu_addr[7:0] >= `MMU_SEG_FIRST
                   && seg_rel[7:4] == 4'h0) begin
         unique case (seg_rel[1:0])
            `SEG_OFS_BASE:  nxt_rdata = seg_base_ff[seg_idx*8 +: 8];
            `SEG_OFS_LIMIT: nxt_rdata = seg_limit_ff[seg_idx*8 +: 8];
            `SEG_OFS_EN:    nxt_rdata = {7'h00, seg_en_ff[seg_idx]};
            default:        nxt_rdata = `RST_BYTE;
         endcase
      end
   end

   // configuration read answer, one cycle after the request
   // data holds until the next configuration read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= `RST_BYTE;
      end else begin
         rvalid_ff <= cfg_rd;
         if (cfg_rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // violation pulse and cause
   // a suppressed access leaves all configuration state untouched
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fault_ff <= 1'b0;
         cause_ff <= FLT_NONE;
      end else begin
         fault_ff <= cpu_req && !allow;
         if (cpu_req && !allow) begin
            cause_ff <= nxt_cause;
         end
      end
   end

   // forward permitted accesses outside the configuration range
   // configuration accesses raise no res_req but still load res_we, res_addr and res_wdata
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         res_req_ff   <= 1'b0;
         res_we_ff    <= 1'b0;
         res_addr_ff  <= 16'h0000;
         res_wdata_ff <= `RST_BYTE;
      end else begin
         res_req_ff <= cpu_req && allow && !(in_page && is_mmu);
         if (cpu_req && allow) begin
            res_we_ff    <= cpu_we;
            res_addr_ff  <= cpu_addr;
            res_wdata_ff <= cpu_wdata;
         end
      end
   end

   // outputs
   assign cpu_rvalid      = rvalid_ff;
   assign cpu_rdata       = rdata_ff;
   assign cpu_fault       = fault_ff;
   assign cpu_fault_cause = cause_ff;
   assign res_req         = res_req_ff;
   assign res_we          = res_we_ff;
   assign res_addr        = res_addr_ff;
   assign res_wdata       = res_wdata_ff;
   assign seg_table_base  = stb_ff;
   assign attrs_ready     = boot_done_ff;
endmodule // mode_sfr_mmu_guard

// ---- mode_sfr_mmu_guard_chk.sv ----
`timescale 1ns/1ps
module mode_sfr_mmu_guard_chk (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     rst_n,
   // access side
   input wire logic                     cipher_strap,
   input wire logic                     cpu_req,
   input wire logic [15:0]              cpu_addr,
   input wire sfr_guard_pkg::cpu_mode_e cpu_mode,
   // answers
   input wire logic                     cpu_fault,
   input wire sfr_guard_pkg::fault_e    cpu_fault_cause,
   input wire logic                     res_req,
   input wire logic [15:0]              res_addr,
   input wire logic [15:0]              seg_table_base,
   input wire logic                     attrs_ready
);
   import sfr_guard_pkg::*;
   logic pg;
   logic mem;
   logic sys;
   logic lgl;
   // access classification
   assign pg  = cpu_req && cpu_addr[15:8] == 8'hFF;
   assign mem = cpu_req && cpu_addr[15:8] != 8'hFF;
   assign sys = cpu_mode == MODE_SYSTEM;
   assign lgl = cpu_mode != cpu_mode_e'(2'h3);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_mmu_deny;
      pg && cpu_addr[7:5] == 3'h2 && lgl && !sys
         |=> cpu_fault && cpu_fault_cause == FLT_MMU_CFG;
   endproperty
   a_mmu_deny: assert property (p_mmu_deny) else $error("mmu open");
   property p_stb_hold;
      cpu_req && !sys |=> $stable(seg_table_base);
   endproperty
   a_stb_hold: assert property (p_stb_hold) else $error("stb moved");
   property p_unit_sys;
      pg && sys && cpu_addr[7:6] == 2'h2 && cpu_addr[5:4] != 2'h0 |=> res_req;
   endproperty
   a_unit_sys: assert property (p_unit_sys) else $error("unit shut");
   property p_core_open;
      pg && lgl && cpu_addr[7:6] == 2'h0
         |=> res_req && res_addr == $past(cpu_addr);
   endproperty
   a_core_open: assert property (p_core_open) else $error("core shut");
   property p_cipher_off;
      !cipher_strap [*4] ##0 (pg && lgl && cpu_addr[7:4] == 4'h8)
         |=> cpu_fault && cpu_fault_cause == FLT_UNIT;
   endproperty
   a_cipher_off: assert property (p_cipher_off) else $error("cipher");
   property p_partition;
      mem && lgl && (cpu_addr[15] != (cpu_mode == MODE_ISOLATED))
         |=> cpu_fault && cpu_fault_cause == FLT_PARTITION;
   endproperty
   a_partition: assert property (p_partition) else $error("partition");
   property p_seg_boot;
      mem && cpu_mode == MODE_USER && !cpu_addr[15] && !attrs_ready
         |=> cpu_fault && cpu_fault_cause == FLT_SEGMENT;
   endproperty
   a_seg_boot: assert property (p_seg_boot) else $error("seg open");
   property p_reset_dflt;
      $rose(rst_n) |-> seg_table_base == 16'h0000 && !attrs_ready;
   endproperty
   a_reset_dflt: assert property (p_reset_dflt) else $error("reset");
   property p_mode_bad;
      cpu_req && !lgl |=> cpu_fault && cpu_fault_cause == FLT_MODE && !res_req;
   endproperty
   a_mode_bad: assert property (p_mode_bad) else $error("bad mode");
endmodule // mode_sfr_mmu_guard_chk

bind mode_sfr_mmu_guard mode_sfr_mmu_guard_chk u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .cipher_strap(cipher_strap),
   .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_mode(cpu_mode),
   .cpu_fault(cpu_fault), .cpu_fault_cause(cpu_fault_cause),
   .res_req(res_req), .res_addr(res_addr),
   .seg_table_base(seg_table_base), .attrs_ready(attrs_ready)
);

// ---- cpu_model.sv ----
`timescale 1ns/1ps
module cpu_model (
   // clock
   input  wire logic                      core_clk,
   // access drive
   output logic                           cpu_req,
   output logic                           cpu_we,
   output logic [15:0]                    cpu_addr,
   output logic [7:0]                     cpu_wdata,
   output sfr_guard_pkg::cpu_mode_e       cpu_mode,
   // answer
   input  wire logic                      cpu_rvalid,
   input  wire logic [7:0]                cpu_rdata,
   input  wire logic                      cpu_fault,
   input  wire sfr_guard_pkg::fault_e     cpu_fault_cause,
   input  wire logic                      res_req
);
   import sfr_guard_pkg::*;
   // idle bus at time zero
   initial begin
      cpu_req = 1'b0;
      cpu_we = 1'b0;
      cpu_addr = 16'h0000;
      cpu_wdata = 8'h00;
      cpu_mode = MODE_SYSTEM;
   end
   // one access, answer taken one edge later
   task automatic acc(input logic w, input logic [15:0] a,
      input logic [7:0] d, input cpu_mode_e m, output logic rv,
      output logic [7:0] rd, output logic fl, output fault_e cs,
      output logic fw);
      @(negedge core_clk);
      cpu_req = 1'b1;
      cpu_we = w;
      cpu_addr = a;
      cpu_wdata = d;
      cpu_mode = m;
      @(negedge core_clk);
      rv = cpu_rvalid;
      rd = cpu_rdata;
      fl = cpu_fault;
      cs = cpu_fault_cause;
      fw = res_req;
      // released lines show no stale value
      cpu_req = 1'b0;
      cpu_we = ~cpu_we;
      cpu_addr = ~cpu_addr;
      cpu_wdata = ~cpu_wdata;
   endtask
endmodule // cpu_model

// ---- tb_mode_sfr_mmu_guard.sv ----
`timescale 1ns/1ps
module tb_mode_sfr_mmu_guard;
   import sfr_guard_pkg::*;
   logic        core_clk, rst_n, cipher_strap, cpu_req, cpu_we, cpu_rvalid;
   logic        cpu_fault, res_req, res_we, attrs_ready, rv, fl, fw;
   logic [15:0] cpu_addr, res_addr, seg_table_base;
   logic [7:0]  cpu_wdata, cpu_rdata, res_wdata, rd;
   cpu_mode_e   cpu_mode;
   fault_e      cpu_fault_cause, cs;
   int          error_cnt, n_checks;
   localparam cpu_mode_e ms = MODE_SYSTEM;
   localparam cpu_mode_e mu = MODE_USER;
   localparam cpu_mode_e mi = MODE_ISOLATED;

   mode_sfr_mmu_guard dut (
      .core_clk(core_clk), .rst_n(rst_n), .cipher_strap(cipher_strap),
      .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_mode(cpu_mode), .cpu_rvalid(cpu_rvalid),
      .cpu_rdata(cpu_rdata), .cpu_fault(cpu_fault),
      .cpu_fault_cause(cpu_fault_cause), .res_req(res_req),
      .res_we(res_we), .res_addr(res_addr), .res_wdata(res_wdata),
      .seg_table_base(seg_table_base), .attrs_ready(attrs_ready));
   cpu_model u_cpu (
      .core_clk(core_clk), .cpu_req(cpu_req), .cpu_we(cpu_we),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_mode(cpu_mode),
      .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata), .cpu_fault(cpu_fault),
      .cpu_fault_cause(cpu_fault_cause), .res_req(res_req));

   task automatic check(input string s, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // k: 0 silent, 1 read data, 2 refused, 3 forwarded
   task automatic go(input logic w, input logic [15:0] a, input logic [7:0] d,
      input cpu_mode_e m, input int k, input fault_e c = FLT_NONE);
      u_cpu.acc(w, a, d, m, rv, rd, fl, cs, fw);
      check("rvalid", 16'(rv), 16'(k == 1));
      check("fault", 16'(fl), 16'(k == 2));
      check("fwd", 16'(fw), 16'(k == 3));
      if (k == 2) begin
         check("cause", 16'(cs), 16'(c));
      end
      if (k == 3) begin
         check("res_addr", res_addr, a);
         check("res_we", 16'(res_we), 16'(w));
         check("res_wdata", 16'(res_wdata), 16'(d));
      end
   endtask
   task automatic do_reset;
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
   endtask
   task automatic t_defaults;
      check("stb", seg_table_base, 16'h0000);
      check("ready", 16'(attrs_ready), 16'h0000);
      go(1'b0, 16'hFF42, 8'h00, ms, 1);
      check("grant", 16'(rd), 16'h0000);
      go(1'b0, 16'hFF48, 8'h00, ms, 1);
      check("base", 16'(rd), 16'h00FF);
      go(1'b0, 16'hFF4A, 8'h00, ms, 1);
      check("en", 16'(rd), 16'h0000);
      go(1'b0, 16'hFF90, 8'h00, mu, 2, FLT_UNIT);
   endtask
   task automatic t_mmu;
      go(1'b1, 16'hFF40, 8'h34, mu, 2, FLT_MMU_CFG);
      go(1'b0, 16'hFF42, 8'h00, mi, 2, FLT_MMU_CFG);
      go(1'b1, 16'hFF40, 8'h34, ms, 0);
      go(1'b1, 16'hFF41, 8'h12, ms, 0);
      go(1'b1, 16'hFF41, 8'h77, mi, 2, FLT_MMU_CFG);
      check("stb", seg_table_base, 16'h1234);
      go(1'b0, 16'hFF40, 8'h00, ms, 1);
      check("rdata", 16'(rd), 16'h0034);
   endtask
   task automatic t_units;
      for (int i = 0; i < 3; i++) begin
         go(1'b0, 16'hFF10, 8'h00, cpu_mode_e'(2'(i)), 3);
      end
      for (int u = 1; u < 4; u++) begin
         go(1'b0, 16'hFF80 + 16'(u * 16), 8'h00, mu, 2, FLT_UNIT);
         go(1'b1, 16'hFF80 + 16'(u * 16), 8'h5A, ms, 3);
      end
      go(1'b0, 16'hFFC0, 8'h00, ms, 2, FLT_UNIT);
      go(1'b1, 16'hFF42, 8'h02, ms, 0);
      go(1'b0, 16'hFF90, 8'h00, mu, 3);
      go(1'b0, 16'hFFA0, 8'h00, mu, 2, FLT_UNIT);
      go(1'b0, 16'hFF90, 8'h00, mi, 2, FLT_UNIT);
      go(1'b1, 16'hFF43, 8'h04, ms, 0);
      go(1'b1, 16'hFFA0, 8'h00, mi, 3);
   endtask
   task automatic t_cipher;
      go(1'b0, 16'hFF80, 8'h00, ms, 2, FLT_UNIT);
      @(negedge core_clk);
      cipher_strap = 1'b1;
      repeat (3) @(negedge core_clk);
      go(1'b0, 16'hFF80, 8'h00, ms, 3);
      cipher_strap = 1'b0;
   endtask
   task automatic t_seg;
      go(1'b0, 16'h1234, 8'h00, mu, 2, FLT_SEGMENT);
      go(1'b0, 16'h1234, 8'h00, ms, 3);
      go(1'b1, 16'hFF44, 8'h01, ms, 0);
      check("ready", 16'(attrs_ready), 16'h0001);
      go(1'b0, 16'h1234, 8'h00, mu, 2, FLT_SEGMENT);
      go(1'b1, 16'hFF48, 8'h10, ms, 0);
      go(1'b1, 16'hFF49, 8'h1F, ms, 0);
      go(1'b1, 16'hFF4A, 8'h01, ms, 0);
      go(1'b1, 16'h1FFF, 8'hC3, mu, 3);
      go(1'b0, 16'h2000, 8'h00, mu, 2, FLT_SEGMENT);
      go(1'b0, 16'h9000, 8'h00, mi, 2, FLT_SEGMENT);
   endtask
   task automatic t_part;
      go(1'b0, 16'h9000, 8'h00, mu, 2, FLT_PARTITION);
      go(1'b1, 16'h8000, 8'h00, ms, 2, FLT_PARTITION);
      go(1'b0, 16'h7FFF, 8'h00, mi, 2, FLT_PARTITION);
      go(1'b0, 16'h1234, 8'h00, cpu_mode_e'(2'h3), 2, FLT_MODE);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // hang guard
   initial begin
      repeat (4000) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      cipher_strap = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      do_reset();
      t_defaults();
      t_mmu();
      t_units();
      t_cipher();
      t_seg();
      t_part();
      do_reset();
      t_defaults();
      finish_test();
   end
endmodule // tb_mode_sfr_mmu_guard
